//--- verilog/masap_consts.vh
// constants shared by the serial audio port design files
// Notes on behaviour
// R01 - all converters share master and frame clocks
// R02 - reset release aligned; start is deterministic
// R03 - bit clock, frame clock, four data outputs
// R04 - two-channel: odd channel first, then even
// R05 - every sample leaves most significant bit first
// R06 - slave, long channel: trailing zeros after sample
// R07 - slave, short channel: truncate to received cycles
// R08 - TDM: eight channels, frame sync rise starts
// R09 - TDM: 32-cycle slots, sample left-justified
// R10 - receiver samples TDM data on rising edge
// R11 - TDM stream first, complement second, all driven
// R12 - format selector: LJ, I2S, TDM, reserved
// R13 - three speed ranges: single, double, quad
// R14 - mode selector: three master speeds, auto slave
// R15 - slave compares divided master clock to frame
// R16 - master clock divider 1, 1.5, 2, 3, 4
// R17 - master: 64 or 256 bit clocks per frame
// R18 - divided ratio 256, 128, 64 per speed
// R19 - TDM master limits dividers at double, quad
// R20 - system keeps clock ratio constant per mode
// R21 - external master should use 64 or 256; the bench model runs 80 and 40
// R22 - master drives clocks; slave takes them as inputs
// R23 - control port enable overrides configuration pins
// R24 - slot bits after the sample are zero
// R25 - auto-detect thresholds: single, double, quad speed
`ifndef MASAP_CONSTS_VH
`define MASAP_CONSTS_VH
`define MASAP_REG_CTRL 8'h00
`define MASAP_REG_STAT 8'h04
`define MASAP_CTRL_RESET 8'h00
`define MASAP_FMT_LSB 0
`define MASAP_SPD_LSB 2
`define MASAP_DIV_LSB 4
`define MASAP_CPEN_BIT 7
`define MASAP_STAT_ERR_BIT 2
`define MASAP_STAT_SLAVE_BIT 3
`define MASAP_STAT_CPEN_BIT 4
`define MASAP_FMT_LJ 2'h0
`define MASAP_FMT_I2S 2'h1
`define MASAP_FMT_TDM 2'h2
`define MASAP_SPD_SINGLE 2'h0
`define MASAP_SPD_DOUBLE 2'h1
`define MASAP_SPD_QUAD 2'h2
`define MASAP_SPD_SLAVE 2'h3
`define MASAP_DIV_1 3'h0
`define MASAP_DIV_1P5 3'h1
`define MASAP_DIV_2 3'h2
`define MASAP_DIV_3 3'h3
`define MASAP_DIV_4 3'h4
`define MASAP_HALF_DIV_1 4'h2
`define MASAP_HALF_DIV_1P5 4'h3
`define MASAP_HALF_DIV_2 4'h4
`define MASAP_HALF_DIV_3 4'h6
`define MASAP_HALF_DIV_4 4'h8
`define MASAP_RATIO_SINGLE 12'h100
`define MASAP_RATIO_DOUBLE 12'h080
`define MASAP_RATIO_QUAD 12'h040
`define MASAP_STEP_2CH 13'h0080
`define MASAP_STEP_TDM 13'h0200
`define MASAP_LAST_BIT_2CH 8'h3F
`define MASAP_LAST_BIT_TDM 8'hFF
`define MASAP_SLOT_LAST 5'h1F
`define MASAP_DET_SINGLE 12'h0C0
`define MASAP_DET_DOUBLE 12'h060
`define MASAP_DET_MAX 12'hFFF
`endif

//--- verilog/masap_mclk_div.v
// master clock divider producing one tick per divided master clock period
`timescale 1ns/100ps
module masap_mclk_div (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [3:0] period,
  output reg tick
);
  // pclk cycles elapsed in the current divided period
  reg [3:0] cnt;

  // free-running modulo counter, one tick at each wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      tick <= 1'b0;
    end else if (ce) begin
      if (cnt >= period - 4'h1) begin
        cnt <= 4'h0;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 4'h1;
        tick <= 1'b0;
      end
    end
  end
endmodule // masap_mclk_div

//--- verilog/masap_sample_mem.v
// per-channel sample store with one write port and a registered read port
`timescale 1ns/100ps
module masap_sample_mem #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire pclk,
  input wire ce,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  // storage words, one per channel
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // write and registered read
  always @(posedge pclk) begin
    if (ce) begin
      if (wr_en)
        mem[wr_addr] <= wr_data;
      if (rd_en)
        rd_data <= mem[rd_addr];
    end
  end
endmodule // masap_sample_mem

//--- verilog/masap_port.v
// serial audio port: configuration, clock generation, framing and shifting
`timescale 1ns/100ps
`include "masap_consts.vh"
module masap_port #(
  parameter SAMPLE_W = 24
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire format_select_hi,
  input wire format_select_lo,
  input wire speed_select_hi,
  input wire speed_select_lo,
  input wire [2:0] divider_select,
  input wire sample_write,
  input wire [2:0] sample_channel,
  input wire [SAMPLE_W-1:0] sample_data,
  input wire bit_clock_in,
  output reg bit_clock_out,
  output wire bit_clock_oe_n,
  input wire frame_clock_in,
  output reg frame_clock_out,
  output wire frame_clock_oe_n,
  output reg serial_out_first,
  output reg serial_out_second,
  output reg serial_out_third,
  output reg serial_out_fourth
);

  // divided ratio of master clock to frame clock per speed
  function [11:0] ratio_of;
    input [1:0] s;
    begin
      case (s)
        `MASAP_SPD_SINGLE: ratio_of = `MASAP_RATIO_SINGLE;
        `MASAP_SPD_DOUBLE: ratio_of = `MASAP_RATIO_DOUBLE;
        default: ratio_of = `MASAP_RATIO_QUAD;
      endcase
    end
  endfunction

  // pclk cycles per divided master clock (pclk runs at twice master clock)
  function [3:0] half_div_of;
    input [2:0] d;
    begin
      case (d)
        `MASAP_DIV_1: half_div_of = `MASAP_HALF_DIV_1;
        `MASAP_DIV_1P5: half_div_of = `MASAP_HALF_DIV_1P5;
        `MASAP_DIV_2: half_div_of = `MASAP_HALF_DIV_2;
        `MASAP_DIV_3: half_div_of = `MASAP_HALF_DIV_3;
        default: half_div_of = `MASAP_HALF_DIV_4;
      endcase
    end
  endfunction

  // speed class from divided ticks counted over one frame
  function [1:0] classify;
    input [11:0] n;
    begin
      if (n >= `MASAP_DET_SINGLE)
        classify = `MASAP_SPD_SINGLE;
      else if (n >= `MASAP_DET_DOUBLE)
        classify = `MASAP_SPD_DOUBLE;
      else
        classify = `MASAP_SPD_QUAD;
    end
  endfunction

  // software control word
  reg [7:0] ctrl;
  // pin settings caught once after reset release
  reg armed;
  reg [1:0] pin_fmt;
  reg [1:0] pin_spd;
  reg [2:0] pin_div;
  // master generator state
  reg [11:0] acc;
  reg bclk_m;
  reg [7:0] bcnt;
  // slave edge tracking
  reg bclk_q;
  reg fs_last;
  reg fr_prev;
  reg [4:0] scnt;
  // channel sequencing and prefetch
  reg [2:0] cur_idx;
  reg pf_busy;
  reg [1:0] pf_lane;
  reg [2:0] pf_idx;
  reg rd_ok_q;
  reg [1:0] rd_lane_q;
  // next and current sample words per data lane
  reg [SAMPLE_W-1:0] nxt [0:3];
  reg [SAMPLE_W-1:0] cur [0:3];
  // slave speed detection
  reg [11:0] dcnt;
  reg [1:0] det_spd;
  integer l;
  // loop index for the shift register process, kept apart from the decode loop
  integer m;

  // effective configuration: register when enabled, else latched pins
  wire cpen = ctrl[`MASAP_CPEN_BIT];
  wire [1:0] fmt = cpen ? ctrl[`MASAP_FMT_LSB +: 2] : pin_fmt; // R23 R12
  wire [1:0] spd = cpen ? ctrl[`MASAP_SPD_LSB +: 2] : pin_spd; // R23 R14
  wire [2:0] dv = cpen ? ctrl[`MASAP_DIV_LSB +: 3] : pin_div; // R23 R16
  wire slave = (spd == `MASAP_SPD_SLAVE);
  wire tdm = (fmt == `MASAP_FMT_TDM);
  wire i2s = (fmt == `MASAP_FMT_I2S);
  wire lj = (fmt == `MASAP_FMT_LJ);

  // reserved format, unknown divider, or a TDM master speed the divider forbids
  wire bad_tdm = ~slave & tdm & (((spd == `MASAP_SPD_DOUBLE) & (dv < `MASAP_DIV_2)) |
    ((spd == `MASAP_SPD_QUAD) & (dv != `MASAP_DIV_4))); // R19
  wire cfg_err = (fmt == 2'h3) | (dv > `MASAP_DIV_4) | bad_tdm; // R12
  wire run = armed & ~cfg_err;
  wire m_run = run & ~slave;
  wire s_run = run & slave;

  // frame length in pclk cycles and half bit periods per frame
  wire [3:0] half_div = half_div_of(dv);
  wire [15:0] frame_prod = {4'h0, ratio_of(spd)} * {12'h000, half_div}; // R18
  wire [11:0] modv = frame_prod[11:0];
  wire [12:0] step = tdm ? `MASAP_STEP_TDM : `MASAP_STEP_2CH; // R17
  wire [12:0] acc_sum = {1'b0, acc} + step;
  wire m_edge = (acc_sum >= {1'b0, modv});
  wire [7:0] last_bit = tdm ? `MASAP_LAST_BIT_TDM : `MASAP_LAST_BIT_2CH;
  wire [7:0] nb = (bcnt == last_bit) ? 8'h00 : bcnt + 8'h01;

  // falling bit clock edges: data changes here, receiver samples on rise
  wire mfall = m_run & m_edge & bclk_m; // R10
  wire sfall = s_run & bclk_q & ~bit_clock_in;
  wire ev = mfall | sfall;
  wire fs_rise = frame_clock_in & ~fs_last;

  // sample store read port
  wire rd_en = pf_busy;
  wire [2:0] rd_addr = tdm ? pf_idx : {pf_lane, pf_idx[0]};
  wire [SAMPLE_W-1:0] rd_data;
  // divided master clock tick
  wire tk;

  // handshake: ready follows the clock enable, error on unmapped address
  wire hit_ctrl = (paddr == `MASAP_REG_CTRL);
  wire hit = hit_ctrl | (paddr == `MASAP_REG_STAT);
  assign pready = ce;
  assign pslverr = psel & penable & ~hit;

  // pins are driven only as master, enables low while driving
  assign bit_clock_oe_n = ~m_run; // R22
  assign frame_clock_oe_n = ~m_run; // R22

  // channel start and channel index decoded at each falling edge
  reg ev_start;
  reg [2:0] ev_idx;
  always @* begin
    if (slave) begin
      if (tdm) begin
        ev_start = fs_rise | (scnt == `MASAP_SLOT_LAST); // R08 R09
        ev_idx = fs_rise ? 3'h0 : cur_idx + 3'h1; // R08
      end else begin
        ev_start = (frame_clock_in != fs_last); // R06 R07
        ev_idx = {2'b00, lj ? ~frame_clock_in : frame_clock_in}; // R04
      end
    end else begin
      ev_start = (nb[4:0] == 5'h00); // R09
      ev_idx = tdm ? nb[7:5] : {2'b00, nb[5]}; // R04 R08
    end
  end

  // bit presented on each lane at the current edge
  reg [3:0] next_bit;
  always @* begin
    next_bit = 4'h0;
    for (l = 0; l < 4; l = l + 1) begin
      if (ev_start)
        next_bit[l] = ~i2s & nxt[l][SAMPLE_W-1]; // R05
      else
        next_bit[l] = cur[l][SAMPLE_W-1]; // R05
    end
  end

  // apb register access and pin capture after reset release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `MASAP_CTRL_RESET;
      prdata <= 32'h00000000;
      armed <= 1'b0;
      pin_fmt <= 2'h0;
      pin_spd <= 2'h0;
      pin_div <= 3'h0;
    end else if (ce) begin
      // latch straps in the first cycle after release
      if (!armed) begin
        armed <= 1'b1; // R02
        pin_fmt <= {format_select_hi, format_select_lo};
        pin_spd <= {speed_select_hi, speed_select_lo};
        pin_div <= divider_select;
      end
      // write takes effect in the access phase
      if (psel && penable && pwrite && hit_ctrl)
        ctrl <= pwdata[7:0];
      // read data prepared during the setup phase
      if (psel && !penable && !pwrite) begin
        if (paddr == `MASAP_REG_CTRL)
          prdata <= {24'h000000, ctrl};
        else if (paddr == `MASAP_REG_STAT)
          prdata <= {27'h0000000, cpen, slave, cfg_err,
            slave ? det_spd : spd}; // R13
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // master bit clock and frame clock generation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 12'h000;
      bclk_m <= 1'b0;
      bcnt <= 8'hFF;
      bit_clock_out <= 1'b0;
      frame_clock_out <= 1'b0;
    end else if (ce) begin
      if (!m_run) begin
        // idle: restart the frame cleanly when running again
        acc <= 12'h000;
        bclk_m <= 1'b0;
        bcnt <= 8'hFF;
        bit_clock_out <= 1'b0;
        frame_clock_out <= 1'b0;
      end else if (m_edge) begin
        // half bit period elapsed: toggle bit clock
        acc <= acc_sum[11:0] - modv; // R17 R18
        bclk_m <= ~bclk_m;
        bit_clock_out <= ~bclk_m; // R03 R22
        if (bclk_m) begin
          bcnt <= nb;
          if (tdm)
            frame_clock_out <= (nb == 8'h00); // R08
          else if (lj)
            frame_clock_out <= ~nb[5]; // R04
          else
            frame_clock_out <= nb[5]; // R04
        end
      end else begin
        acc <= acc_sum[11:0];
      end
    end
  end

  // slave clock edge tracking and slot bit counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q <= 1'b0;
      fs_last <= 1'b0;
      fr_prev <= 1'b0;
      scnt <= 5'h00;
    end else if (ce) begin
      bclk_q <= bit_clock_in;
      fr_prev <= frame_clock_in;
      if (sfall) begin
        fs_last <= frame_clock_in;
        scnt <= ev_start ? 5'h00 : scnt + 5'h01; // R09
      end
    end
  end

  // slave speed detection: divided ticks per frame period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcnt <= 12'h000;
      det_spd <= `MASAP_SPD_SINGLE;
    end else if (ce) begin
      if (slave && frame_clock_in && !fr_prev) begin
        det_spd <= classify(dcnt); // R15 R25
        dcnt <= 12'h000;
      end else if (tk && dcnt != `MASAP_DET_MAX) begin
        dcnt <= dcnt + 12'h001; // R15
      end
    end
  end

  // channel tracking and prefetch of the next channel's samples
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_idx <= 3'h0;
      pf_busy <= 1'b0;
      pf_lane <= 2'h0;
      pf_idx <= 3'h0;
      rd_ok_q <= 1'b0;
      rd_lane_q <= 2'h0;
    end else if (ce) begin
      rd_ok_q <= pf_busy;
      rd_lane_q <= pf_lane;
      if (ev && ev_start) begin
        // new channel: fetch words for the channel after it
        cur_idx <= ev_idx;
        pf_busy <= 1'b1;
        pf_lane <= 2'h0;
        pf_idx <= tdm ? ev_idx + 3'h1 : ev_idx ^ 3'h1; // R04 R08
      end else if (pf_busy) begin
        pf_lane <= pf_lane + 2'h1;
        if (tdm || pf_lane == 2'h3)
          pf_busy <= 1'b0;
      end
    end
  end

  // sample shift registers: load at channel start, zeros shifted in
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (m = 0; m < 4; m = m + 1) begin
        nxt[m] <= {SAMPLE_W{1'b0}};
        cur[m] <= {SAMPLE_W{1'b0}};
      end
    end else if (ce) begin
      if (rd_ok_q)
        nxt[rd_lane_q] <= rd_data;
      if (ev) begin
        for (m = 0; m < 4; m = m + 1) begin
          if (ev_start && i2s)
            cur[m] <= nxt[m]; // I2S: one zero bit before the sample
          else if (ev_start)
            cur[m] <= {nxt[m][SAMPLE_W-2:0], 1'b0}; // R05
          else
            cur[m] <= {cur[m][SAMPLE_W-2:0], 1'b0}; // R24 R06 R07
        end
      end
    end
  end

  // serial data outputs change on the falling bit clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_first <= 1'b0;
      serial_out_second <= 1'b0;
      serial_out_third <= 1'b0;
      serial_out_fourth <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        serial_out_first <= 1'b0;
        serial_out_second <= 1'b0;
        serial_out_third <= 1'b0;
        serial_out_fourth <= 1'b0;
      end else if (ev && tdm) begin
        serial_out_first <= next_bit[0]; // R11
        serial_out_second <= ~next_bit[0]; // R11
        serial_out_third <= 1'b0; // R11
        serial_out_fourth <= 1'b0; // R11
      end else if (ev) begin
        serial_out_first <= next_bit[0]; // R03
        serial_out_second <= next_bit[1];
        serial_out_third <= next_bit[2];
        serial_out_fourth <= next_bit[3];
      end
    end
  end

  // master clock divider ahead of the rate logic
  masap_mclk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .period(half_div),
    .tick(tk)
  );

  // sample store: written by the converter side, read by prefetch
  masap_sample_mem #(
    .WIDTH(SAMPLE_W),
    .DEPTH(8),
    .AW(3)
  ) u_mem (
    .pclk(pclk),
    .ce(ce),
    .wr_en(sample_write),
    .wr_addr(sample_channel),
    .wr_data(sample_data),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

endmodule // masap_port

//--- verif/masap_port_sva.sv
// assertion checker watching the serial audio port pins
`timescale 1ns/100ps
module masap_port_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire bit_clock_in,
  input wire bit_clock_out,
  input wire bit_clock_oe_n,
  input wire frame_clock_out,
  input wire frame_clock_oe_n,
  input wire serial_out_first,
  input wire serial_out_second,
  input wire serial_out_third,
  input wire serial_out_fourth
);
  reg [7:0] cfg; // last control byte written
  reg [9:0] st; // cycles since that byte changed, saturating
  reg [8:0] nb; // bit clock rises in the current frame
  reg seen; // counting began at a settled frame start
  reg pb; // bit clock one cycle ago
  reg pf; // frame clock one cycle ago
  wire ok = cfg[7] & (st == 10'h3FF); // register settings in force for a while
  wire fr = frame_clock_out & ~pf; // frame clock rise
  wire tbad = (cfg[3:2] == 2'h1 & cfg[6:4] < 3'h2) | (cfg[3:2] == 2'h2 & cfg[6:4] != 3'h4);
  wire val = cfg[1:0] != 2'h3 & cfg[6:4] <= 3'h4 & !(cfg[1:0] == 2'h2 & tbad);
  wire mst = ok & val & cfg[3:2] != 2'h3; // master with a usable setting
  wire slv = ok & val & cfg[3:2] == 2'h3; // slave with a usable setting
  wire tdm = ok & val & cfg[1:0] == 2'h2; // time-slot format running
  wire [3:0] sd = {serial_out_fourth, serial_out_third, serial_out_second, serial_out_first};
  // follow control writes, settle time and bit clocks per frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= 8'h00; st <= 10'h000; nb <= 9'h000; seen <= 1'b0; pb <= 1'b0; pf <= 1'b0;
    end else begin
      pb <= bit_clock_out;
      pf <= frame_clock_out;
      if (fr) begin
        nb <= 9'h000; seen <= ok;
      end else if (bit_clock_out & ~pb) nb <= nb + 9'h001;
      if (psel & penable & pready & pwrite & paddr == 8'h00 & pwdata[7:0] != cfg) begin
        cfg <= pwdata[7:0]; st <= 10'h000; seen <= 1'b0;
      end else if (st != 10'h3FF) st <= st + 10'h001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe_pair; bit_clock_oe_n == frame_clock_oe_n; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock enables differ");
  property p_drive; mst |-> !bit_clock_oe_n; endproperty
  a_drive: assert property (p_drive) else $error("master clocks not driven");
  property p_slave; slv |-> bit_clock_oe_n; endproperty
  a_slave: assert property (p_slave) else $error("slave drives clocks");
  property p_refuse; ok && !val |-> bit_clock_oe_n && sd == 4'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("bad setting not idle");
  property p_tdm_inv; tdm |-> serial_out_second != serial_out_first; endproperty
  a_tdm_inv: assert property (p_tdm_inv) else $error("second lane not inverse");
  property p_tdm_quiet; tdm |-> !serial_out_third && !serial_out_fourth; endproperty
  a_tdm_quiet: assert property (p_tdm_quiet) else $error("spare lanes active");
  property p_hold_m; mst && bit_clock_out && $past(bit_clock_out) |-> $stable(sd); endproperty
  a_hold_m: assert property (p_hold_m) else $error("data moved while clock high");
  property p_hold_s; slv && bit_clock_in && $past(bit_clock_in) |-> $stable(sd); endproperty
  a_hold_s: assert property (p_hold_s) else $error("slave data moved");
  property p_bits; mst && fr && seen |-> nb == (cfg[1:0] == 2'h2 ? 9'h100 : 9'h040); endproperty
  a_bits: assert property (p_bits) else $error("bit clocks per frame wrong");
  property p_sync; tdm && fr |-> ##[1:16] !frame_clock_out; endproperty
  a_sync: assert property (p_sync) else $error("frame sync too long");
endmodule // masap_port_sva
bind masap_port masap_port_sva i_masap_port_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .bit_clock_in(bit_clock_in), .bit_clock_out(bit_clock_out), .bit_clock_oe_n(bit_clock_oe_n),
  .frame_clock_out(frame_clock_out), .frame_clock_oe_n(frame_clock_oe_n),
  .serial_out_first(serial_out_first), .serial_out_second(serial_out_second),
  .serial_out_third(serial_out_third), .serial_out_fourth(serial_out_fourth));

//--- verif/masap_dsp_model.sv
// receiving processor model: captures frames, makes clocks when the port is slave
`timescale 1ns/100ps
module masap_dsp_model (
  input wire pclk,
  input wire slv,
  input wire [7:0] bpc,
  input wire pol,
  input wire bclk,
  input wire fclk,
  input wire [3:0] sd,
  output logic m_bclk,
  output logic m_fclk,
  output logic [255:0][3:0] fr,
  output logic [8:0] cnt,
  output logic [11:0] len,
  output logic [7:0] nfr
);
  logic [255:0][3:0] sh; // frame being caught
  logic [8:0] n; // bits caught so far
  logic [11:0] t; // cycles since frame start
  logic pb; // bit clock at the last cycle
  logic pf; // active frame level at the last bit
  logic [2:0] ph; // phase within a generated bit
  logic [7:0] bi; // bit within the generated frame
  wire [7:0] nbi = (bi + 8'h01 == {bpc[6:0], 1'b0}) ? 8'h00 : bi + 8'h01; // next bit
  initial begin
    m_bclk = 0; m_fclk = 0; ph = 0; bi = 0; pb = 0; pf = 0; n = 0; t = 0;
    nfr = 0; cnt = 0; len = 0;
  end
  // sample on rising bit clock; a frame starts where the frame line turns active
  always @(posedge pclk) begin
    pb <= bclk;
    t <= t + 12'h001;
    if (bclk & !pb) begin
      pf <= fclk ^ pol;
      n <= n + 9'h001;
      sh <= {sh[254:0], sd};
      if ((fclk ^ pol) & !pf) begin
        fr <= sh; cnt <= n; len <= t; t <= 12'h001; n <= 9'h001; nfr <= nfr + 8'h01;
        sh <= '0;
        sh[0] <= sd;
      end
    end
  end
  // clock master: fixed ratio, frame line moves with the falling bit clock; still when idle
  always @(posedge pclk) begin
    if (slv) begin
      ph <= ph + 3'h1;
      if (ph == 3'h3) m_bclk <= 1'b1;
      if (ph == 3'h7) begin
        m_bclk <= 1'b0; bi <= nbi; m_fclk <= nbi < bpc;
      end
    end
  end
endmodule // masap_dsp_model

//--- verif/tb.sv
// self-checking bench for the serial audio port
`timescale 1ns/100ps
module tb;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 0, bpc = 40, nfr;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, swr = 0, slv = 0, pol = 0, bco, bcoe_n, fco, fcoe_n, m_bclk, m_fclk;
  logic [2:0] sch = 0;
  logic [23:0] sdat = 0;
  logic [3:0] sd;
  logic [255:0][3:0] fr;
  logic [8:0] cnt;
  logic [11:0] len;
  int n_fail = 0, comparisons = 0;
  wire bclk = bcoe_n ? m_bclk : bco; // resolved bit clock line
  wire fclk = fcoe_n ? m_fclk : fco; // resolved frame line
  always #2 pclk = ~pclk;
  masap_port i_masap_port (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .format_select_hi(1'b0), .format_select_lo(1'b0),
    .speed_select_hi(1'b0), .speed_select_lo(1'b0), .divider_select(3'h0),
    .sample_write(swr), .sample_channel(sch), .sample_data(sdat), .bit_clock_in(bclk),
    .bit_clock_out(bco), .bit_clock_oe_n(bcoe_n), .frame_clock_in(fclk),
    .frame_clock_out(fco), .frame_clock_oe_n(fcoe_n), .serial_out_first(sd[0]),
    .serial_out_second(sd[1]), .serial_out_third(sd[2]), .serial_out_fourth(sd[3]));
  masap_dsp_model i_masap_dsp_model (.pclk(pclk), .slv(slv), .bpc(bpc), .pol(pol),
    .bclk(bclk), .fclk(fclk), .sd(sd), .m_bclk(m_bclk), .m_fclk(m_fclk), .fr(fr),
    .cnt(cnt), .len(len), .nfr(nfr));
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  // one bus transfer; read data and error flag land in q and err
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin n_fail++; print_verdict; end
    else begin q = prdata; err = pslverr; psel <= 0; penable <= 0; end
  endtask
  task automatic frames(input int m);
    int k;
    logic [7:0] v;
    for (int j = 0; j < m; j++) begin
      v = nfr; k = 0;
      while (nfr === v && k < 4000) begin @(posedge pclk); k++; end
      if (k >= 4000) begin n_fail++; print_verdict; end
    end
  endtask
  function automatic logic [23:0] smp(input int c);
    return 24'h96A53C ^ (24'h010203 * c[23:0]);
  endfunction
  // n bits of one lane from frame bit k0 on, first bit highest
  function automatic logic [31:0] w(input int l, input int k0, input int nb);
    logic [31:0] r;
    r = 0;
    for (int i = 0; i < nb; i++) r = {r[30:0], fr[cnt - 1 - k0 - i][l]};
    return r;
  endfunction
  function automatic int flen(input logic [7:0] c);
    int h[5] = '{2, 3, 4, 6, 8};
    return (256 >> c[3:2]) * h[c[6:4]];
  endfunction
  task automatic chk2(input int b, input int o);
    int nw;
    nw = (b - o < 24) ? b - o : 24;
    cmp(cnt, 2 * b);
    for (int l = 0; l < 4; l++) for (int c = 0; c < 2; c++) begin
      cmp(w(l, c * b + o, nw), smp(2 * l + c) >> (24 - nw));
      if (b - o > nw) cmp(w(l, c * b + o + nw, b - o - nw), 0);
      if (o) cmp(w(l, c * b, 1), 0);
    end
  endtask
  logic [7:0] cfgs[6] = '{8'h90, 8'hA8, 8'hB5, 8'hCA, 8'h86, 8'h83};
  logic [7:0] c;
  logic bad;
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h00, 0); cmp(q, 0);
    apb(0, 8'h08, 0); cmp({31'h0, err}, 1); cmp(q, 0);
    fork
      apb(0, 8'h04, 0);
      begin repeat (2) @(posedge pclk); ce <= 0; repeat (3) @(posedge pclk); ce <= 1; end
    join
    cmp(q, 0);
    for (int k = 0; k < 8; k++) begin @(posedge pclk); swr <= 1; sch <= k[2:0]; sdat <= smp(k); end
    @(posedge pclk); swr <= 0;
    frames(3); cmp(len, flen(8'h00)); chk2(32, 0);
    foreach (cfgs[i]) begin
      c = cfgs[i];
      bad = c[1:0] == 3 || (c[1:0] == 2 && (c[3:2] == 1 && c[6:4] < 2 || c[3:2] == 2 && c[6:4] != 4));
      pol <= c[1:0] == 2'h1;
      apb(1, 8'h00, {24'h0, c}); apb(0, 8'h00, 0); cmp(q, c);
      apb(0, 8'h04, 0); cmp(q, {27'h0, 1'b1, 1'b0, bad, c[3:2]});
      if (bad) begin
        repeat (1100) @(posedge pclk); cmp(bcoe_n, 1); cmp(sd, 0);
      end else begin
        frames(3); cmp(len, flen(c));
        if (c[1:0] == 2) begin
          cmp(cnt, 256);
          for (int k = 0; k < 8; k++) begin
            cmp(w(0, 32 * k, 24), smp(k));
            cmp(w(0, 32 * k + 24, 8), 0);
          end
        end else chk2(32, c[0]);
      end
    end
    pol <= 0;
    apb(1, 8'h00, 8'h8C);
    for (int b = 40; b > 0; b -= 20) begin
      bpc <= b[7:0]; slv <= 1;
      frames(4); cmp(len, 16 * b);
      apb(0, 8'h04, 0); cmp(q, {27'h3, 1'b0, b >= 24 ? 2'h0 : 2'h1});
      chk2(b, 0);
    end
    print_verdict;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    print_verdict;
  end
endmodule // tb
